// ### include/xmd_pkg.sv
// Shared constants and carriers for the translation-miss / debug entry unit
package xmd_pkg;

   // Register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFF_MACH_STATE = 8'h00;
   localparam logic [7:0] OFF_SPC_NC = 8'h04;
   localparam logic [7:0] OFF_SST_NC = 8'h08;
   localparam logic [7:0] OFF_SPC_C = 8'h0C;
   localparam logic [7:0] OFF_SST_C = 8'h10;
   localparam logic [7:0] OFF_FAULT_ADDR = 8'h14;
   localparam logic [7:0] OFF_SYNDROME = 8'h18;
   localparam logic [7:0] OFF_VEC_PREFIX = 8'h1C;
   localparam logic [7:0] OFF_DBG_STATUS = 8'h20;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

   // Machine state bit positions
   localparam int MS_AUX_UNIT_ALLOW = 25;
   localparam int MS_AUX_UNIT_EXC_ALLOW = 19;
   localparam int MS_WAIT_STATE_ALLOW = 18;
   localparam int MS_CRITICAL_IRQ_ALLOW = 17;
   localparam int MS_EXTERNAL_IRQ_ALLOW = 15;
   localparam int MS_USER_LEVEL_FLAG = 14;
   localparam int MS_FLOAT_AVAIL = 13;
   localparam int MS_MACHINE_CHECK_ALLOW = 12;
   localparam int MS_FLOAT_EXC_MODE_LO = 11;
   localparam int MS_DBG_WAIT_ALLOW = 10;
   localparam int MS_DBG_IRQ_ALLOW = 9;
   localparam int MS_FLOAT_EXC_MODE_HI = 8;
   localparam int MS_INSTR_XLATE_ON = 5;
   localparam int MS_DATA_XLATE_ON = 4;

   // Bits cleared on a non-critical entry
   localparam logic [31:0] MS_CLR_NONCRIT =
      (32'h0000_0001 << MS_AUX_UNIT_ALLOW) |
      (32'h0000_0001 << MS_AUX_UNIT_EXC_ALLOW) |
      (32'h0000_0001 << MS_WAIT_STATE_ALLOW) |
      (32'h0000_0001 << MS_EXTERNAL_IRQ_ALLOW) |
      (32'h0000_0001 << MS_USER_LEVEL_FLAG) |
      (32'h0000_0001 << MS_FLOAT_AVAIL) |
      (32'h0000_0001 << MS_FLOAT_EXC_MODE_LO) |
      (32'h0000_0001 << MS_DBG_WAIT_ALLOW) |
      (32'h0000_0001 << MS_FLOAT_EXC_MODE_HI) |
      (32'h0000_0001 << MS_INSTR_XLATE_ON) |
      (32'h0000_0001 << MS_DATA_XLATE_ON);
   // Critical entry also drops the critical and debug enables
   localparam logic [31:0] MS_CLR_CRIT = MS_CLR_NONCRIT |
      (32'h0000_0001 << MS_CRITICAL_IRQ_ALLOW) |
      (32'h0000_0001 << MS_DBG_IRQ_ALLOW);

   // Syndrome bit positions
   localparam int SYN_STORE_FLAG = 23;
   localparam int SYN_MCHECK_INSTR_FLAG = 31;

   // Fixed low halves of the vectors
   localparam logic [15:0] VEC_LO_DMISS = 16'h1100;
   localparam logic [15:0] VEC_LO_IMISS = 16'h1200;
   localparam logic [15:0] VEC_LO_DEBUG = 16'h2000;

   // Values after reset
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] RST_VEC_PREFIX = 16'h0000;
   localparam logic [2:0] RST_IRQ = 3'h0;

   // Interrupt status bit positions
   localparam int IRQ_DMISS = 0;
   localparam int IRQ_IMISS = 1;
   localparam int IRQ_DEBUG = 2;

   // Debug events, also the layout of debug_event_status[7:0]
   typedef struct packed {
      logic branch_taken_event;
      logic data_addr_match_event;
      logic data_value_match_event;
      logic instr_addr_match_event;
      logic instr_complete_event;
      logic trap_event;
      logic fault_chain_event;
      logic unconditional_event;
   } xmd_dbg_ev_type;

   // Data access report from the pipeline and translation buffer
   typedef struct packed {
      logic valid;
      logic xlate_hit;
      logic is_store;
      logic [31:0] instr_pc;
      logic [31:0] eff_addr;
   } xmd_dacc_type;

   // Execution attempt report for an instruction fetch
   typedef struct packed {
      logic exec;
      logic xlate_hit;
      logic [31:0] instr_pc;
   } xmd_iacc_type;

   // Debug report from the debug event logic
   typedef struct packed {
      xmd_dbg_ev_type ev;
      logic [31:0] cur_pc;
      logic [31:0] next_pc;
      logic [31:0] first_vec;
   } xmd_dbg_type;

   // Entry chosen in one cycle
   typedef enum logic [2:0] {
      K_NONE = 3'b000,
      K_DEBUG = 3'b001,
      K_DMISS = 3'b010,
      K_IMISS = 3'b011,
      K_RET_CRIT = 3'b100,
      K_RET_NONCRIT = 3'b101
   } xmd_kind_type;

endpackage : xmd_pkg

// ### core/xmd_dbg_sel.sv
`timescale 1ns/10ps
// Picks the critical save address for a debug entry
module xmd_dbg_sel (
   input wire xmd_pkg::xmd_dbg_type dbg_in,
   input wire logic allow_in,
   output logic take_out,
   output logic [31:0] save_pc_out,
   output logic [7:0] status_set_out
);
   import xmd_pkg::*;

   // Event grouping and address choice
   always_comb begin
      take_out = allow_in && (dbg_in.ev != 8'h00);
      status_set_out = take_out ? dbg_in.ev : 8'h00;
      if (dbg_in.ev.branch_taken_event ||
          dbg_in.ev.data_addr_match_event ||
          dbg_in.ev.instr_addr_match_event ||
          dbg_in.ev.trap_event) begin
         // Synchronous, causing instruction
         save_pc_out = dbg_in.cur_pc;
      end else if (dbg_in.ev.data_value_match_event ||
                   dbg_in.ev.instr_complete_event) begin
         // Synchronous, following instruction
         save_pc_out = dbg_in.next_pc;
      end else if (dbg_in.ev.fault_chain_event) begin
         // Asynchronous, first vector
         save_pc_out = dbg_in.first_vec;
      end else begin
         // Asynchronous, next to execute
         save_pc_out = dbg_in.next_pc;
      end
   end

endmodule : xmd_dbg_sel

// ### core/xmd_irq_ctl.sv
`timescale 1ns/10ps
// Sticky entry status, mask and one level interrupt
module xmd_irq_ctl (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [2:0] event_in,
   input wire logic status_wr_in,
   input wire logic mask_wr_in,
   input wire logic [2:0] wdata_in,
   output logic [2:0] status_out,
   output logic [2:0] mask_out,
   output logic irq_out
);
   import xmd_pkg::*;

   // Write-one-clear; a new event wins over its clear
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         status_out <= RST_IRQ;
      end else begin
         status_out <= (status_out &
            ~(status_wr_in ? wdata_in : 3'h0)) | event_in;
      end
   end

   // Mask register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mask_out <= RST_IRQ;
      end else if (mask_wr_in) begin
         mask_out <= wdata_in;
      end
   end

   // Level output from the next status value
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(((status_out &
            ~(status_wr_in ? wdata_in : 3'h0)) | event_in) &
            (mask_wr_in ? wdata_in : mask_out));
      end
   end

endmodule : xmd_irq_ctl

// ### core/xmd_entry_core.sv
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
// How it works
// - Data access misses translation: raise entry
// - Data miss saves faulting instruction address
// - Data miss saves missed data address
// - Syndrome: store flag, keep mcheck, clear rest
// - Data miss precise, vector prefix plus 1100
// - Miss saves state, clears noncritical bit set
// - Executed fetch misses translation: raise entry
// - Instruction miss saves address, vector 1200
// - Six synchronous, two asynchronous debug events
// - Debug save address: causing or following
// - Chain: first vector; unconditional: next
// - Debug saves state, clears all but mcheck
// - Debug vectors to prefix plus 2000
// - Debug status records the causing event kind
// - Critical return restores address and state
// - Noncritical return restores address and state
module xmd_entry_core (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire xmd_pkg::xmd_dacc_type DACC_IN,
   input wire xmd_pkg::xmd_iacc_type IACC_IN,
   input wire xmd_pkg::xmd_dbg_type DBG_IN,
   input wire logic RET_CRIT_IN,
   input wire logic RET_NONCRIT_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [31:0] REG_RDATA_OUT,
   output logic REDIRECT_OUT,
   output logic [31:0] NEW_PC_OUT,
   output logic [31:0] MACH_STATE_OUT,
   output logic IRQ_OUT
);
   import xmd_pkg::*;

   // Address match for one register offset
   function automatic logic reg_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
      reg_hit = (addr == off);
   endfunction : reg_hit

   // Architectural registers
   logic [31:0] mach_state_r; // Live machine state
   logic [31:0] saved_pc_noncrit_r; // Noncritical return address
   logic [31:0] saved_state_noncrit_r; // Noncritical saved state
   logic [31:0] saved_pc_crit_r; // Critical return address
   logic [31:0] saved_state_crit_r; // Critical saved state
   logic [31:0] fault_data_addr_r; // Missed data address
   logic [31:0] exc_syndrome_r; // Syndrome bits
   logic [15:0] vector_prefix_r; // Upper half of all vectors
   logic [7:0] debug_event_status_r; // Sticky debug kinds
   logic redirect_r; // One-cycle redirect pulse
   logic [31:0] new_pc_r; // Redirect target
   logic [31:0] rdata_r; // Read answer

   // Decode and selection
   logic dmiss; // Data translation miss now
   logic imiss; // Instruction translation miss now
   logic dbg_take; // Debug entry possible now
   logic [31:0] dbg_save_pc; // Debug save address
   logic [7:0] dbg_set; // Debug status bits to set
   xmd_kind_type kind; // Chosen action this cycle
   logic [31:0] syndrome_nxt; // Syndrome for a data miss
   logic [2:0] irq_event; // Entry events to status
   logic [2:0] irq_status; // Sticky status
   logic [2:0] irq_mask; // Mask
   logic wr_irq_status; // Status write strobe
   logic wr_irq_mask; // Mask write strobe

   // Debug event grouping and saved address
   xmd_dbg_sel u_dbg_sel (
      .dbg_in(DBG_IN),
      .allow_in(mach_state_r[MS_DBG_IRQ_ALLOW]),
      .take_out(dbg_take),
      .save_pc_out(dbg_save_pc),
      .status_set_out(dbg_set)
   );

   // Miss detection from translation results
   always_comb begin
      // Data side: translation on and no matching entry
      dmiss = DACC_IN.valid && !DACC_IN.xlate_hit &&
              mach_state_r[MS_DATA_XLATE_ON];
      // Fetch side: only when execution is attempted
      imiss = IACC_IN.exec && !IACC_IN.xlate_hit &&
              mach_state_r[MS_INSTR_XLATE_ON];
   end

   // Priority: debug, data miss, fetch miss, returns
   always_comb begin
      if (dbg_take) begin
         // Critical entry beats everything
         kind = K_DEBUG;
      end else if (dmiss) begin
         // Older data access before the fetch
         kind = K_DMISS;
      end else if (imiss) begin
         // Fetch miss
         kind = K_IMISS;
      end else if (RET_CRIT_IN) begin
         // Return from critical entry
         kind = K_RET_CRIT;
      end else if (RET_NONCRIT_IN) begin
         // Return from noncritical entry
         kind = K_RET_NONCRIT;
      end else begin
         // Nothing to do
         kind = K_NONE;
      end
   end

   // Syndrome for a data miss
   always_comb begin
      syndrome_nxt = RST_WORD;
      syndrome_nxt[SYN_MCHECK_INSTR_FLAG] =
         exc_syndrome_r[SYN_MCHECK_INSTR_FLAG];
      syndrome_nxt[SYN_STORE_FLAG] = DACC_IN.is_store;
   end

   // Register write strobes for the interrupt block
   always_comb begin
      wr_irq_status = REG_WR_IN &&
                      reg_hit(REG_ADDR_IN, OFF_IRQ_STATUS);
      wr_irq_mask = REG_WR_IN && reg_hit(REG_ADDR_IN, OFF_IRQ_MASK);
      irq_event = 3'h0;
      irq_event[IRQ_DMISS] = (kind == K_DMISS);
      irq_event[IRQ_IMISS] = (kind == K_IMISS);
      irq_event[IRQ_DEBUG] = (kind == K_DEBUG);
   end

   // Sticky entry status and interrupt output
   xmd_irq_ctl u_irq_ctl (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .event_in(irq_event),
      .status_wr_in(wr_irq_status),
      .mask_wr_in(wr_irq_mask),
      .wdata_in(REG_WDATA_IN[2:0]),
      .status_out(irq_status),
      .mask_out(irq_mask),
      .irq_out(IRQ_OUT)
   );

   // Machine state: entries clear, returns restore
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         mach_state_r <= RST_WORD;
      end else begin
         unique case (kind)
            K_DEBUG: begin
               // Only machine check allow survives
               mach_state_r <= mach_state_r & ~MS_CLR_CRIT;
            end
            K_DMISS, K_IMISS: begin
               // Critical, mcheck and debug interrupt allows survive
               mach_state_r <= mach_state_r & ~MS_CLR_NONCRIT;
            end
            K_RET_CRIT: begin
               // Restore from critical copy
               mach_state_r <= saved_state_crit_r;
            end
            K_RET_NONCRIT: begin
               // Restore from noncritical copy
               mach_state_r <= saved_state_noncrit_r;
            end
            K_NONE: begin
               // Software write when nothing is taken
               if (REG_WR_IN &&
                   reg_hit(REG_ADDR_IN, OFF_MACH_STATE)) begin
                  mach_state_r <= REG_WDATA_IN;
               end
            end
         endcase
      end
   end

   // Noncritical save pair
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         saved_pc_noncrit_r <= RST_WORD;
         saved_state_noncrit_r <= RST_WORD;
      end else if (kind == K_DMISS) begin
         // Instruction whose data address missed
         saved_pc_noncrit_r <= DACC_IN.instr_pc;
         saved_state_noncrit_r <= mach_state_r;
      end else if (kind == K_IMISS) begin
         // Instruction whose fetch missed
         saved_pc_noncrit_r <= IACC_IN.instr_pc;
         saved_state_noncrit_r <= mach_state_r;
      end else if (REG_WR_IN) begin
         // Software access to the pair
         if (reg_hit(REG_ADDR_IN, OFF_SPC_NC)) begin
            saved_pc_noncrit_r <= REG_WDATA_IN;
         end
         if (reg_hit(REG_ADDR_IN, OFF_SST_NC)) begin
            saved_state_noncrit_r <= REG_WDATA_IN;
         end
      end
   end

   // Critical save pair
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         saved_pc_crit_r <= RST_WORD;
         saved_state_crit_r <= RST_WORD;
      end else if (kind == K_DEBUG) begin
         // Address depends on the debug event kind
         saved_pc_crit_r <= dbg_save_pc;
         saved_state_crit_r <= mach_state_r;
      end else if (REG_WR_IN) begin
         // Software access to the pair
         if (reg_hit(REG_ADDR_IN, OFF_SPC_C)) begin
            saved_pc_crit_r <= REG_WDATA_IN;
         end
         if (reg_hit(REG_ADDR_IN, OFF_SST_C)) begin
            saved_state_crit_r <= REG_WDATA_IN;
         end
      end
   end

   // Fault address and syndrome
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         fault_data_addr_r <= RST_WORD;
         exc_syndrome_r <= RST_WORD;
      end else if (kind == K_DMISS) begin
         // Capture the failed access
         fault_data_addr_r <= DACC_IN.eff_addr;
         exc_syndrome_r <= syndrome_nxt;
      end else if (REG_WR_IN) begin
         // Software access
         if (reg_hit(REG_ADDR_IN, OFF_FAULT_ADDR)) begin
            fault_data_addr_r <= REG_WDATA_IN;
         end
         if (reg_hit(REG_ADDR_IN, OFF_SYNDROME)) begin
            exc_syndrome_r <= REG_WDATA_IN;
         end
      end
   end

   // Vector prefix, software only
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         vector_prefix_r <= RST_VEC_PREFIX;
      end else if (REG_WR_IN &&
                   reg_hit(REG_ADDR_IN, OFF_VEC_PREFIX)) begin
         vector_prefix_r <= REG_WDATA_IN[15:0];
      end
   end

   // Debug status: set wins over write-one-clear
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         debug_event_status_r <= RST_WORD[7:0];
      end else begin
         debug_event_status_r <= (debug_event_status_r &
            ~((REG_WR_IN && reg_hit(REG_ADDR_IN, OFF_DBG_STATUS)) ?
              REG_WDATA_IN[7:0] : 8'h00)) |
            ((kind == K_DEBUG) ? dbg_set : 8'h00);
      end
   end

   // Program counter redirect, same edge as all saves
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         redirect_r <= 1'b0;
         new_pc_r <= RST_WORD;
      end else begin
         redirect_r <= (kind != K_NONE);
         unique case (kind)
            K_DEBUG: begin
               // Debug vector
               new_pc_r <= {vector_prefix_r, VEC_LO_DEBUG};
            end
            K_DMISS: begin
               // Data miss vector
               new_pc_r <= {vector_prefix_r, VEC_LO_DMISS};
            end
            K_IMISS: begin
               // Fetch miss vector
               new_pc_r <= {vector_prefix_r, VEC_LO_IMISS};
            end
            K_RET_CRIT: begin
               // Resume at critical return address
               new_pc_r <= saved_pc_crit_r;
            end
            K_RET_NONCRIT: begin
               // Resume at noncritical return address
               new_pc_r <= saved_pc_noncrit_r;
            end
            K_NONE: begin
               // Hold the last target
               new_pc_r <= new_pc_r;
            end
         endcase
      end
   end

   // Read answer, valid only in the cycle after the strobe
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         rdata_r <= RST_WORD;
      end else if (!REG_RD_IN) begin
         rdata_r <= RST_WORD;
      end else begin
         unique case (REG_ADDR_IN)
            OFF_MACH_STATE: rdata_r <= mach_state_r;
            OFF_SPC_NC: rdata_r <= saved_pc_noncrit_r;
            OFF_SST_NC: rdata_r <= saved_state_noncrit_r;
            OFF_SPC_C: rdata_r <= saved_pc_crit_r;
            OFF_SST_C: rdata_r <= saved_state_crit_r;
            OFF_FAULT_ADDR: rdata_r <= fault_data_addr_r;
            OFF_SYNDROME: rdata_r <= exc_syndrome_r;
            OFF_VEC_PREFIX: rdata_r <= {16'h0000, vector_prefix_r};
            OFF_DBG_STATUS: rdata_r <= {24'h00_0000, debug_event_status_r};
            OFF_IRQ_STATUS: rdata_r <= {29'h0000_0000, irq_status};
            OFF_IRQ_MASK: rdata_r <= {29'h0000_0000, irq_mask};
            default: rdata_r <= RST_WORD; // Unmapped reads zero
         endcase
      end
   end

   // Outputs straight from flops
   assign REG_RDATA_OUT = rdata_r;
   assign REDIRECT_OUT = redirect_r;
   assign NEW_PC_OUT = new_pc_r;
   assign MACH_STATE_OUT = mach_state_r;

endmodule : xmd_entry_core

// ### verif/xmd_entry_checker.sv
`timescale 1ns/10ps
// Port-level entry checks
module xmd_entry_checker (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire xmd_pkg::xmd_dacc_type DACC_IN,
   input wire xmd_pkg::xmd_iacc_type IACC_IN,
   input wire xmd_pkg::xmd_dbg_type DBG_IN,
   input wire logic RET_CRIT_IN,
   input wire logic RET_NONCRIT_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic REDIRECT_OUT,
   input wire logic [31:0] NEW_PC_OUT,
   input wire logic [31:0] MACH_STATE_OUT
);
   import xmd_pkg::*;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   logic dbg_take; // Debug event while allowed
   logic dm_req; // Data miss requested
   logic im_req; // Fetch miss requested
   logic act; // Any action
   logic ms_wr; // Software write to machine state
   assign dbg_take = (|DBG_IN.ev) & MACH_STATE_OUT[MS_DBG_IRQ_ALLOW];
   assign dm_req = DACC_IN.valid & ~DACC_IN.xlate_hit
      & MACH_STATE_OUT[MS_DATA_XLATE_ON];
   assign im_req = IACC_IN.exec & ~IACC_IN.xlate_hit
      & MACH_STATE_OUT[MS_INSTR_XLATE_ON];
   assign act = dbg_take | dm_req | im_req | RET_CRIT_IN | RET_NONCRIT_IN;
   assign ms_wr = REG_WR_IN & (REG_ADDR_IN == OFF_MACH_STATE);
   AST_DMISS_VEC: assert property (dm_req && !dbg_take |=> REDIRECT_OUT
      && NEW_PC_OUT[15:0] == VEC_LO_DMISS) else $error("data miss vector");
   AST_IMISS_VEC: assert property (im_req && !dm_req && !dbg_take
      |=> REDIRECT_OUT && NEW_PC_OUT[15:0] == VEC_LO_IMISS)
      else $error("fetch miss vector");
   AST_DBG_VEC: assert property (dbg_take |=> REDIRECT_OUT
      && NEW_PC_OUT[15:0] == VEC_LO_DEBUG) else $error("debug vector");
   AST_MS_NONCRIT: assert property ((dm_req || im_req) && !dbg_take
      |=> MACH_STATE_OUT == ($past(MACH_STATE_OUT) & ~MS_CLR_NONCRIT))
      else $error("miss state clear");
   AST_MS_CRIT: assert property (dbg_take |=> MACH_STATE_OUT ==
      ($past(MACH_STATE_OUT) & ~MS_CLR_CRIT)) else $error("debug state");
   AST_NO_ACT: assert property (!act |=> !REDIRECT_OUT)
      else $error("redirect without cause");
   AST_ACT_REDIR: assert property (act |=> REDIRECT_OUT)
      else $error("cause without redirect");
   AST_MS_HOLD: assert property (!act && !ms_wr
      |=> $stable(MACH_STATE_OUT)) else $error("state moved idle");
endmodule : xmd_entry_checker

bind xmd_entry_core xmd_entry_checker u_xmd_entry_checker (
   .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .DACC_IN(DACC_IN),
   .IACC_IN(IACC_IN), .DBG_IN(DBG_IN), .RET_CRIT_IN(RET_CRIT_IN),
   .RET_NONCRIT_IN(RET_NONCRIT_IN), .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WR_IN(REG_WR_IN), .REDIRECT_OUT(REDIRECT_OUT),
   .NEW_PC_OUT(NEW_PC_OUT), .MACH_STATE_OUT(MACH_STATE_OUT));

// ### verif/xmd_pipe_model.sv
`timescale 1ns/10ps
// Far-side reports, one per call
module xmd_pipe_model (
   input wire logic clk_in,
   output xmd_pkg::xmd_dacc_type dacc_out,
   output xmd_pkg::xmd_iacc_type iacc_out,
   output xmd_pkg::xmd_dbg_type dbg_out,
   output logic ret_crit_out,
   output logic ret_noncrit_out
);
   import xmd_pkg::*;
   // Idle at time zero
   initial begin
      dacc_out = '0;
      iacc_out = '0;
      dbg_out = '0;
      ret_crit_out = 1'b0;
      ret_noncrit_out = 1'b0;
   end
   // One data access, then invalid with inverted fields
   task automatic data_req(input logic [31:0] pc, input logic [31:0] ea,
                           input logic st, input logic hit);
      @(posedge clk_in);
      dacc_out <= {1'b1, hit, st, pc, ea};
      @(posedge clk_in);
      dacc_out <= {1'b0, ~hit, ~st, ~pc, ~ea};
   endtask : data_req
   // One execution attempt
   task automatic fetch_req(input logic [31:0] pc, input logic hit);
      @(posedge clk_in);
      iacc_out <= {1'b1, hit, pc};
      @(posedge clk_in);
      iacc_out <= {1'b0, ~hit, ~pc};
   endtask : fetch_req
   // One debug event and its addresses
   task automatic dbg_req(input logic [7:0] ev, input logic [31:0] cur,
                          input logic [31:0] nxt, input logic [31:0] fst);
      @(posedge clk_in);
      dbg_out <= {ev, cur, nxt, fst};
      @(posedge clk_in);
      dbg_out <= {8'h00, ~cur, ~nxt, ~fst};
   endtask : dbg_req
   // One return
   task automatic ret_req(input logic crit);
      @(posedge clk_in);
      ret_crit_out <= crit;
      ret_noncrit_out <= ~crit;
      @(posedge clk_in);
      ret_crit_out <= 1'b0;
      ret_noncrit_out <= 1'b0;
   endtask : ret_req
endmodule : xmd_pipe_model

// ### verif/xmd_entry_core_test.sv
`timescale 1ns/10ps
// Bench for the entry unit
module xmd_entry_core_test;
   import xmd_pkg::*;
   // All state bits set
   localparam logic [31:0] MS_ALL =
      MS_CLR_CRIT | (32'h0000_0001 << MS_MACHINE_CHECK_ALLOW);
   localparam logic [15:0] PFX = 16'hABCD; // Vector prefix used
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata, new_pc, ms, exp_pc;
   logic redir, irq;
   xmd_dacc_type dacc;
   xmd_iacc_type iacc;
   xmd_dbg_type dbg;
   logic ret_c, ret_n;
   int errors = 0;
   int n_compared = 0;
   always #25 clk = ~clk;
   xmd_pipe_model u_xmd_pipe_model (.clk_in(clk), .dacc_out(dacc),
      .iacc_out(iacc), .dbg_out(dbg), .ret_crit_out(ret_c),
      .ret_noncrit_out(ret_n));
   xmd_entry_core u_xmd_entry_core (.CLK_IN(clk), .RST_N_IN(rst_n),
      .DACC_IN(dacc), .IACC_IN(iacc), .DBG_IN(dbg), .RET_CRIT_IN(ret_c),
      .RET_NONCRIT_IN(ret_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .REDIRECT_OUT(redir), .NEW_PC_OUT(new_pc), .MACH_STATE_OUT(ms),
      .IRQ_OUT(irq));
   // Compare and count
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Counts, verdict, end of run
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   // One-cycle register write
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   // Read, data taken next cycle
   task automatic chk_reg(input string n, input logic [7:0] a,
                          input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(n, rdata, e);
   endtask : chk_reg
   // One-cycle redirect to target
   task automatic chk_redir(input logic [31:0] e);
      #1 check("redirect", {31'h0, redir}, 32'h1);
      check("new_pc", new_pc, e);
      @(posedge clk);
      #1 check("redirect end", {31'h0, redir}, 32'h0);
   endtask : chk_redir
   // Reset values, unmapped read
   task automatic s_reset;
      chk_reg("state", OFF_MACH_STATE, RST_WORD);
      chk_reg("prefix", OFF_VEC_PREFIX, RST_WORD);
      chk_reg("unmapped", 8'h40, RST_WORD);
      check("irq", {31'h0, irq}, 32'h0);
      reg_wr(OFF_VEC_PREFIX, {16'h0000, PFX});
      reg_wr(OFF_IRQ_MASK, 32'h0000_0005);
   endtask : s_reset
   // Data miss load/store, then return
   task automatic s_dmiss;
      for (int st = 0; st < 2; st++) begin
         reg_wr(OFF_MACH_STATE, MS_ALL);
         reg_wr(OFF_SYNDROME, 32'hFFFF_FFFF);
         u_xmd_pipe_model.data_req(32'h0000_4404, 32'h00C0_0010, st[0],
            1'b0);
         chk_redir({PFX, VEC_LO_DMISS});
         check("state", ms, MS_ALL & ~MS_CLR_NONCRIT);
         check("irq", {31'h0, irq}, 32'h1);
         chk_reg("spc", OFF_SPC_NC, 32'h0000_4404);
         chk_reg("sst", OFF_SST_NC, MS_ALL);
         chk_reg("fault", OFF_FAULT_ADDR, 32'h00C0_0010);
         chk_reg("syn", OFF_SYNDROME, (32'h1 << SYN_MCHECK_INSTR_FLAG)
            | (32'(st) << SYN_STORE_FLAG));
         reg_wr(OFF_IRQ_STATUS, 32'h0000_0001);
         chk_reg("status", OFF_IRQ_STATUS, 32'h0);
         check("irq clear", {31'h0, irq}, 32'h0);
         u_xmd_pipe_model.ret_req(1'b0);
         chk_redir(32'h0000_4404);
         check("state back", ms, MS_ALL);
      end
   endtask : s_dmiss
   // Hit ignored, fetch miss, masked irq
   task automatic s_imiss;
      u_xmd_pipe_model.data_req(32'h0000_0100, 32'h0000_0200, 1'b0, 1'b1);
      #1 check("hit", {31'h0, redir}, 32'h0);
      u_xmd_pipe_model.fetch_req(32'h0000_5508, 1'b0);
      chk_redir({PFX, VEC_LO_IMISS});
      check("state", ms, MS_ALL & ~MS_CLR_NONCRIT);
      check("masked irq", {31'h0, irq}, 32'h0);
      chk_reg("spc", OFF_SPC_NC, 32'h0000_5508);
      chk_reg("fault kept", OFF_FAULT_ADDR, 32'h00C0_0010);
      chk_reg("status", OFF_IRQ_STATUS, 32'h0000_0002);
      u_xmd_pipe_model.fetch_req(32'h0000_6600, 1'b0);
      #1 check("xlate off", {31'h0, redir}, 32'h0);
   endtask : s_imiss
   // Each debug event, then return
   task automatic s_dbg;
      for (int i = 0; i < 8; i++) begin
         if (i == 1) exp_pc = 32'h0000_0700;
         else if (i == 0 || i == 3 || i == 5) exp_pc = 32'h1000_0014;
         else exp_pc = 32'h1000_0010;
         reg_wr(OFF_MACH_STATE, MS_ALL);
         reg_wr(OFF_DBG_STATUS, 32'h0000_00FF);
         u_xmd_pipe_model.dbg_req(8'h01 << i, 32'h1000_0010,
            32'h1000_0014, 32'h0000_0700);
         chk_redir({PFX, VEC_LO_DEBUG});
         check("state", ms, MS_ALL & ~MS_CLR_CRIT);
         chk_reg("spc", OFF_SPC_C, exp_pc);
         chk_reg("sst", OFF_SST_C, MS_ALL);
         chk_reg("dbg status", OFF_DBG_STATUS, 32'h1 << i);
         u_xmd_pipe_model.ret_req(1'b1);
         chk_redir(exp_pc);
         check("state back", ms, MS_ALL);
      end
      chk_reg("status", OFF_IRQ_STATUS, 32'h0000_0006);
      check("irq", {31'h0, irq}, 32'h1);
   endtask : s_dbg
   // Hang guard
   initial begin
      #3_000_000;
      errors++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      s_reset();
      s_dmiss();
      s_imiss();
      s_dbg();
      stop_test();
   end
endmodule : xmd_entry_core_test
